// ### dpa_arbiter.sv
// Operation
// R1 - CPU wins over DMA on shared bus
// R2 - CPU streak can never starve DMA
// R3 - Lower level number preempts lower precedence
// R4 - Preempted channel finishes current transaction first
// R5 - Fairness interleaves levels two to seven
// R6 - Levels zero and one bypass fairness
// R7 - Shares halve per level from one half
// R8 - Fairness off means pure priority order
// R9 - Round robin among equal level requesters
// R10 - Per channel fixed head of line option
// R11 - 24 channels share 128 descriptors
// R12 - Eight priority levels per channel
// R13 - Start by pin, CPU or chained channel
// R14 - Two interrupts per transfer per channel
// R15 - Transactions can be stalled or cancelled
// R16 - Infinite or 1 to 64K byte count
// R17 - Descriptors chain to next descriptor
// R18 - Descriptors writable while running
// R19 - Single descriptor moves source to sink
// R20 - Decisions only at transaction boundaries
// R21 - Reset idles channels, clears grants, pointers
`timescale 1ns/10ps
`default_nettype none
`include "dpa_defines.svh"
module dpa_arbiter #(
    parameter int NCH   = `DPA_NCH,
    parameter int NDESC = `DPA_NDESC
) (
    input  wire logic                       core_clk,
    input  wire logic                       reset_n,
    input  wire logic                       fair_en,
    input  wire logic                       cpu_bus_req,
    input  wire logic [3*NCH-1:0]           ch_prio,
    input  wire logic [NCH-1:0]             ch_rr_off,
    input  wire logic [$clog2(NDESC)*NCH-1:0] ch_first_desc,
    input  wire logic [NCH-1:0]             ch_chain_en,
    input  wire logic [$clog2(NCH)*NCH-1:0] ch_chain_src,
    input  wire logic [NCH-1:0]             ch_trig_pin,
    input  wire logic [NCH-1:0]             cpu_trig,
    input  wire logic [NCH-1:0]             ch_stall,
    input  wire logic [NCH-1:0]             ch_cancel,
    input  wire logic                       desc_wr_en,
    input  wire logic [$clog2(NDESC)-1:0]   desc_wr_idx,
    input  wire logic [15:0]                desc_wr_count,
    input  wire logic                       desc_wr_inf,
    input  wire logic [$clog2(NDESC)-1:0]   desc_wr_next,
    input  wire logic                       desc_wr_link,
    input  wire logic                       desc_wr_irq0,
    input  wire logic                       desc_wr_irq1,
    input  wire logic [15:0]                desc_wr_src,
    input  wire logic [15:0]                desc_wr_dst,
    input  wire logic                       bus_txn_done,
    output logic                            cpu_grant,
    output logic                            dma_grant,
    output logic [$clog2(NCH)-1:0]          dma_ch,
    output logic [15:0]                     dma_src_addr,
    output logic [15:0]                     dma_dst_addr,
    output logic [NCH-1:0]                  ch_active,
    output logic [NCH-1:0]                  ch_done,
    output logic [NCH-1:0]                  ch_irq_desc,
    output logic [NCH-1:0]                  ch_irq_end
);
    import dpa_pkg::*;
    localparam int CHW = $clog2(NCH);
    localparam int DW  = $clog2(NDESC);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    dpa_desc_s        desc_mem [NDESC];
    dpa_state_e       state;
    logic [CHW-1:0]   rr_ptr [`DPA_NLVL];
    logic [2:0]       streak;
    logic [5:0]       slot;
    logic [NCH-1:0]   pin_s1, pin_s2, pin_s3;
    logic [DW-1:0]    cur [NCH];
    logic [15:0]      rem [NCH];
    logic [15:0]      off [NCH];
    logic [DW-1:0]    next_cur [NCH];
    logic [15:0]      next_rem [NCH];
    logic [15:0]      next_off [NCH];
    logic [NCH-1:0]   next_act, next_done, next_irq0, next_irq1;
    logic [NCH-1:0]   trig, pend;
    logic [NCH-1:0]   lvl_req [`DPA_NLVL];
    logic [2:0]       lvl_min, fav_lvl, sel_lvl;
    logic             fav_ok;
    logic [CHW:0]     sel;
    logic             dma_any, take_cpu, take_dma, sel_fixed;

    // Round robin pick, fixed channels first, then from pointer
    function automatic logic [CHW:0] pick_ch(input logic [NCH-1:0] req,
                                             input logic [NCH-1:0] fixed,
                                             input logic [CHW-1:0] ptr);
        logic [CHW:0] r;
        int           t;
        r = '0;
        t = 0;
        for (int n = NCH - 1; n >= 0; n--) begin
            if (req[n] && fixed[n])
                r = {1'b1, CHW'(n)}; // [R10]
        end
        if (!r[CHW]) begin
            for (int n = NCH - 1; n >= 0; n--) begin
                t = int'(ptr) + n;
                if (t >= NCH)
                    t = t - NCH;
                if (req[t])
                    r = {1'b1, CHW'(t)}; // [R9]
            end
        end
        return r;
    endfunction : pick_ch

    // ------------------------------------------------------------
    // Descriptor pool, writable at any time
    // ------------------------------------------------------------
    // Running channels read all fields but count live, so their updates take effect
    always_ff @(posedge core_clk) begin
        if (desc_wr_en)
            desc_mem[desc_wr_idx] <= '{desc_wr_count, desc_wr_inf, desc_wr_next,
                                       desc_wr_link, desc_wr_irq0, desc_wr_irq1,
                                       desc_wr_src, desc_wr_dst}; // [R18] [R11]
    end

    // ------------------------------------------------------------
    // Trigger sources
    // ------------------------------------------------------------
    // Pins are asynchronous: two flops, third for the edge
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
        end else begin
            pin_s1 <= ch_trig_pin;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // Pin edge, CPU pulse, or completion of the chained channel
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            trig[i] = (pin_s2[i] & ~pin_s3[i]) | cpu_trig[i]
                    | (ch_chain_en[i] & ch_done[ch_chain_src[CHW*i +: CHW]]); // [R13]
        end
    end

    // ------------------------------------------------------------
    // Level selection
    // ------------------------------------------------------------
    // Stalled channels keep their state but do not request
    assign pend = ch_active & ~ch_stall; // [R15]

    always_comb begin
        for (int l = 0; l < `DPA_NLVL; l++)
            lvl_req[l] = '0;
        for (int i = 0; i < NCH; i++)
            lvl_req[ch_prio[3*i +: 3]][i] = pend[i]; // [R12]
        lvl_min = `DPA_LVL_LAST;
        for (int l = `DPA_NLVL - 1; l >= 0; l--) begin
            if (|lvl_req[l])
                lvl_min = 3'(l); // [R3]
        end
        // Trailing zeros of slot: level 2 every 2nd, level 7 every 64th
        fav_ok  = 1'b0;
        fav_lvl = `DPA_LVL_LAST;
        for (int b = 5; b >= 0; b--) begin
            if (slot[b]) begin
                fav_ok  = 1'b1;
                fav_lvl = 3'(b + 2); // [R7]
            end
        end
    end

    // Fairness only arbitrates among levels 2..7
    assign sel_lvl = (fair_en && lvl_min >= `DPA_FAIR_LO && fav_ok
                      && |lvl_req[fav_lvl]) ? fav_lvl : lvl_min; // [R5] [R6] [R8]
    assign sel       = pick_ch(lvl_req[sel_lvl], ch_rr_off, rr_ptr[sel_lvl]);
    assign sel_fixed = ch_rr_off[sel[CHW-1:0]];
    assign dma_any   = |pend;
    // CPU first, unless DMA has waited out a full CPU streak
    assign take_cpu  = cpu_bus_req && !(dma_any && streak >= `DPA_CPU_MAX); // [R1] [R2]
    assign take_dma  = !take_cpu && dma_any;
    assign cpu_grant = (state == DPA_CPU);
    assign dma_grant = (state == DPA_DMA);

    // ------------------------------------------------------------
    // Channel progress
    // ------------------------------------------------------------
    // Count holds bytes minus one; a done transaction moves one byte
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            next_cur[i]  = cur[i];
            next_rem[i]  = rem[i];
            next_off[i]  = off[i];
            next_act[i]  = ch_active[i];
            next_done[i] = 1'b0;
            next_irq0[i] = 1'b0;
            next_irq1[i] = 1'b0;
            if (!ch_active[i] && trig[i]) begin
                next_cur[i] = ch_first_desc[DW*i +: DW];
                next_rem[i] = desc_mem[ch_first_desc[DW*i +: DW]].count;
                next_off[i] = '0;
                next_act[i] = 1'b1;
            end
            if (dma_grant && bus_txn_done && dma_ch == CHW'(i) && ch_active[i]) begin
                next_off[i] = off[i] + 16'h0001; // [R19]
                if (desc_mem[cur[i]].inf) begin
                    next_rem[i] = rem[i]; // [R16]
                end else if (rem[i] != 16'h0000) begin
                    next_rem[i] = rem[i] - 16'h0001; // [R16]
                end else begin
                    next_irq0[i] = desc_mem[cur[i]].irq0; // [R14]
                    if (desc_mem[cur[i]].link) begin
                        next_cur[i] = desc_mem[cur[i]].next; // [R17]
                        next_rem[i] = desc_mem[desc_mem[cur[i]].next].count;
                        next_off[i] = '0;
                    end else begin
                        next_act[i]  = 1'b0;
                        next_done[i] = 1'b1;
                        next_irq1[i] = desc_mem[cur[i]].irq1; // [R14]
                    end
                end
            end
            if (ch_cancel[i])
                next_act[i] = 1'b0; // [R15]
        end
    end

    // Per-channel registers
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ch_active   <= '0; // [R21]
            ch_done     <= '0;
            ch_irq_desc <= '0;
            ch_irq_end  <= '0;
            for (int i = 0; i < NCH; i++) begin
                cur[i] <= '0;
                rem[i] <= '0;
                off[i] <= '0;
            end
        end else begin
            ch_active   <= next_act;
            ch_done     <= next_done;
            ch_irq_desc <= next_irq0;
            ch_irq_end  <= next_irq1;
            cur         <= next_cur;
            rem         <= next_rem;
            off         <= next_off;
        end
    end

    // ------------------------------------------------------------
    // Grant sequencer
    // ------------------------------------------------------------
    // Decide only in idle; a granted transaction always runs to done
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state        <= DPA_IDLE; // [R21]
            streak       <= '0;
            slot         <= `DPA_SLOT_RST;
            dma_ch       <= '0;
            dma_src_addr <= '0;
            dma_dst_addr <= '0;
            for (int l = 0; l < `DPA_NLVL; l++)
                rr_ptr[l] <= CHW'(`DPA_PTR_RST); // [R21]
        end else begin
            case (state)
                DPA_IDLE: begin
                    if (take_cpu) begin
                        state  <= DPA_CPU; // [R1]
                        streak <= dma_any ? streak + 3'd1 : 3'd0; // [R2]
                    end else if (take_dma) begin
                        state        <= DPA_DMA; // [R20]
                        streak       <= '0;
                        dma_ch       <= sel[CHW-1:0];
                        dma_src_addr <= desc_mem[cur[sel[CHW-1:0]]].src + off[sel[CHW-1:0]];
                        dma_dst_addr <= desc_mem[cur[sel[CHW-1:0]]].dst + off[sel[CHW-1:0]];
                        if (sel_lvl >= `DPA_FAIR_LO)
                            slot <= slot + 6'h01; // [R5]
                        if (!sel_fixed)
                            rr_ptr[sel_lvl] <= (sel[CHW-1:0] == CHW'(NCH - 1)) ? '0
                                               : sel[CHW-1:0] + CHW'(1); // [R9]
                    end
                end
                DPA_CPU, DPA_DMA: begin
                    if (bus_txn_done)
                        state <= DPA_IDLE; // [R4]
                end
                default: state <= DPA_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_CPU_FIRST: assert property (@(posedge core_clk) disable iff (!reset_n) // [R1]
        (state == DPA_IDLE && cpu_bus_req && streak < `DPA_CPU_MAX) |=> cpu_grant)
        else $error("cpu not granted first");

    AST_NO_STARVE: assert property (@(posedge core_clk) disable iff (!reset_n) // [R2]
        (state == DPA_IDLE && dma_any && streak == `DPA_CPU_MAX) |=> dma_grant)
        else $error("dma starved by cpu streak");

    AST_LVL_PRIO: assert property (@(posedge core_clk) disable iff (!reset_n) // [R3]
        (state == DPA_IDLE && take_dma && !fair_en)
        |=> dma_grant && ch_prio[3*dma_ch +: 3] == $past(lvl_min))
        else $error("granted level not the highest precedence");

    AST_HOLD: assert property (@(posedge core_clk) disable iff (!reset_n) // [R4]
        (dma_grant && !bus_txn_done) |=> dma_grant && $stable(dma_ch))
        else $error("transaction interrupted before done");

    AST_FAIR: assert property (@(posedge core_clk) disable iff (!reset_n) // [R5]
        (state == DPA_IDLE && take_dma && fair_en && lvl_min >= `DPA_FAIR_LO
         && fav_ok && |lvl_req[fav_lvl])
        |=> ch_prio[3*dma_ch +: 3] == $past(fav_lvl))
        else $error("favoured level skipped");

    // Levels 0 and 1 win even with fairness on
    AST_STRICT01: assert property (@(posedge core_clk) disable iff (!reset_n) // [R6]
        (state == DPA_IDLE && take_dma && lvl_min <= 3'd1)
        |=> ch_prio[3*dma_ch +: 3] == $past(lvl_min))
        else $error("level zero or one bypassed");

    AST_FIXED: assert property (@(posedge core_clk) disable iff (!reset_n) // [R10]
        (state == DPA_IDLE && take_dma && |(lvl_req[sel_lvl] & ch_rr_off))
        |=> ch_rr_off[dma_ch])
        else $error("fixed channel lost a tie");

    AST_RESET: assert property (@(posedge core_clk) disable iff (!reset_n) // [R21]
        $rose(reset_n) |-> !cpu_grant && !dma_grant && ch_active == '0)
        else $error("grant or channel active after reset");

    AST_CANCEL: assert property (@(posedge core_clk) disable iff (!reset_n) // [R15]
        (ch_cancel != '0) |=> (ch_active & $past(ch_cancel)) == '0)
        else $error("cancel ignored");

    // A stalled channel is never the one handed the bus
    AST_NO_STALL: assert property (@(posedge core_clk) disable iff (!reset_n) // [R15]
        (state == DPA_IDLE && take_dma) |-> !ch_stall[sel[CHW-1:0]]
        ##1 (dma_grant && dma_ch == $past(sel[CHW-1:0])))
        else $error("stalled channel granted");
endmodule : dpa_arbiter
`default_nettype wire

// ### dpa_defines.svh
`ifndef DPA_DEFINES_SVH
`define DPA_DEFINES_SVH
// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define DPA_NCH       24
`define DPA_NDESC     128
`define DPA_NLVL      8
// ----------------------------------------------------------------
// Arbitration constants
// ----------------------------------------------------------------
`define DPA_CPU_MAX   3'd4
`define DPA_FAIR_LO   3'd2
`define DPA_LVL_LAST  3'd7
`define DPA_SLOT_RST  6'h00
`define DPA_PTR_RST   0
`endif

// ### dpa_pkg.sv
`default_nettype none
package dpa_pkg;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DPA_IDLE = 2'b00,
        DPA_CPU  = 2'b01,
        DPA_DMA  = 2'b10
    } dpa_state_e;

    typedef struct packed {
        logic [15:0] count;
        logic        inf;
        logic [6:0]  next;
        logic        link;
        logic        irq0;
        logic        irq1;
        logic [15:0] src;
        logic [15:0] dst;
    } dpa_desc_s;
endpackage : dpa_pkg
`default_nettype wire

// ### dpa_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Shared system bus: closes every granted transaction
// ----------------------------------------------------------------
module dpa_bus_model (
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic       cpu_grant,
    input  wire logic       dma_grant,
    input  wire logic [1:0] slow,
    output logic            bus_txn_done
);
    logic [1:0] wait_cnt;

    // One done pulse per grant, after slow extra wait cycles
    always_ff @(posedge core_clk) begin
        if (!reset_n || bus_txn_done) begin
            bus_txn_done <= 1'h0;
            wait_cnt     <= 2'h0;
        end else if (cpu_grant || dma_grant) begin
            bus_txn_done <= (wait_cnt == slow);
            wait_cnt     <= wait_cnt + 2'h1;
        end
    end
endmodule : dpa_bus_model
`default_nettype wire

// ### dpa_arbiter_bench.sv
`timescale 1ns/10ps
`default_nettype none
module dpa_arbiter_bench;
    logic         core_clk = 1'h0;
    logic         reset_n = 1'h0;
    logic         fair_en = 1'h0;
    logic         cpu_bus_req = 1'h0;
    logic [71:0]  ch_prio = {24{3'h7}};
    logic [23:0]  ch_rr_off = '0, ch_chain_en = '0, ch_trig_pin = '0, cpu_trig = '0;
    logic [23:0]  ch_stall = '0, ch_cancel = '0, who, a, b, c;
    logic [167:0] ch_first_desc;
    logic [119:0] ch_chain_src = '0;
    logic         desc_wr_en = 1'h0, desc_wr_inf = 1'h0, desc_wr_link = 1'h0;
    logic         desc_wr_irq0 = 1'h0, desc_wr_irq1 = 1'h0;
    logic [6:0]   desc_wr_idx = '0, desc_wr_next = '0;
    logic [15:0]  desc_wr_count = '0, desc_wr_src = '0, desc_wr_dst = '0, src, dst;
    logic [1:0]   slow = 2'h0;
    logic [71:0]  seen = '0;
    wire logic    bus_txn_done, cpu_grant, dma_grant;
    wire logic [4:0]  dma_ch;
    wire logic [15:0] dma_src_addr, dma_dst_addr;
    wire logic [23:0] ch_active, ch_done, ch_irq_desc, ch_irq_end;
    int           errors = 0, comparisons = 0, n;

    dpa_arbiter dpa_arbiter_inst (.core_clk(core_clk), .reset_n(reset_n), .fair_en(fair_en),
        .cpu_bus_req(cpu_bus_req), .ch_prio(ch_prio), .ch_rr_off(ch_rr_off),
        .ch_first_desc(ch_first_desc), .ch_chain_en(ch_chain_en), .ch_chain_src(ch_chain_src),
        .ch_trig_pin(ch_trig_pin), .cpu_trig(cpu_trig), .ch_stall(ch_stall),
        .ch_cancel(ch_cancel), .desc_wr_en(desc_wr_en), .desc_wr_idx(desc_wr_idx),
        .desc_wr_count(desc_wr_count), .desc_wr_inf(desc_wr_inf), .desc_wr_next(desc_wr_next),
        .desc_wr_link(desc_wr_link), .desc_wr_irq0(desc_wr_irq0), .desc_wr_irq1(desc_wr_irq1),
        .desc_wr_src(desc_wr_src), .desc_wr_dst(desc_wr_dst), .bus_txn_done(bus_txn_done),
        .cpu_grant(cpu_grant), .dma_grant(dma_grant), .dma_ch(dma_ch),
        .dma_src_addr(dma_src_addr), .dma_dst_addr(dma_dst_addr), .ch_active(ch_active),
        .ch_done(ch_done), .ch_irq_desc(ch_irq_desc), .ch_irq_end(ch_irq_end));
    dpa_bus_model dpa_bus_model_inst (.core_clk(core_clk), .reset_n(reset_n),
        .cpu_grant(cpu_grant), .dma_grant(dma_grant), .slow(slow),
        .bus_txn_done(bus_txn_done));

    // ----------------------------------------------------------------
    // Clock, pulse catcher, watchdog
    // ----------------------------------------------------------------
    initial begin
        forever #20 core_clk = ~core_clk;
    end
    // Pulses last one cycle, so latch them for later judging
    always @(posedge core_clk) begin
        seen <= seen | {ch_done, ch_irq_desc, ch_irq_end};
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        report_and_stop();
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic report_and_stop;
        if (errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [63:0] got, input logic [63:0] want);
        comparisons++;
        if (got !== want) begin
            errors++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, got, want);
        end
    endtask : check
    task automatic tick;
        @(posedge core_clk);
        #1;
    endtask : tick
    // Waits for the next grant, records owner, then waits for release
    task automatic take(output logic [23:0] owner);
        int k;
        k = 0;
        while (cpu_grant !== 1'h1 && dma_grant !== 1'h1 && k < 50) begin
            tick();
            k++;
        end
        owner = (cpu_grant === 1'h1) ? 24'hC0 : {19'h0, dma_ch};
        src = dma_src_addr;
        dst = dma_dst_addr;
        while ((cpu_grant === 1'h1 || dma_grant === 1'h1) && k < 50) begin
            tick();
            k++;
        end
        if (k >= 50) check(24'hDEAD, 24'h0);
    endtask : take
    // Flags are {inf, link, irq0, irq1}; sink sits 4000 above source
    task automatic wdesc(input logic [6:0] idx, input logic [15:0] cnt,
                         input logic [3:0] flg, input logic [6:0] nxt, input logic [15:0] sa);
        desc_wr_idx = idx;
        desc_wr_count = cnt;
        {desc_wr_inf, desc_wr_link, desc_wr_irq0, desc_wr_irq1} = flg;
        desc_wr_next = nxt;
        desc_wr_src = sa;
        desc_wr_dst = sa + 16'h4000;
        desc_wr_en = 1'h1;
        tick();
        desc_wr_en = 1'h0;
        tick();
    endtask : wdesc
    task automatic go(input logic [23:0] mask);
        cpu_trig = mask;
        tick();
        cpu_trig = '0;
    endtask : go
    // Cancel everything and let the last transaction drain
    task automatic stop;
        ch_cancel = '1;
        tick();
        ch_cancel = '0;
        repeat (8) tick();
    endtask : stop

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_simple;
        wdesc(3, 16'h1, 4'h6, 40, 16'h1000);
        wdesc(40, 16'h0, 4'h1, 0, 16'h2000);
        wdesc(9, 16'h0, 4'h0, 0, 16'h3000);
        ch_chain_en[9] = 1'h1;
        ch_chain_src[45+:5] = 5'h03;
        go(24'h8);
        check(ch_active[3], 1);
        take(who);
        check({who, src, dst}, {24'h3, 16'h1000, 16'h5000});
        take(who);
        check({who, src}, {24'h3, 16'h1001});
        take(who);
        check({who, src}, {24'h3, 16'h2000});
        take(who);
        check({who, src}, {24'h9, 16'h3000});
        check({seen[51], seen[27], seen[26], seen[3], ch_active[3]}, 5'h1A);
        wdesc(9, 16'h0, 4'h0, 0, 16'h3300);
        go(24'h200);
        take(who);
        check({who, src}, {24'h9, 16'h3300});
        wdesc(10, 16'h0, 4'h0, 0, 16'h0A00);
        ch_trig_pin[10] = 1'h1;
        take(who);
        check(who, 24'hA);
        ch_trig_pin[10] = 1'h0;
    endtask : t_simple
    task automatic t_cpu;
        wdesc(4, 16'h0, 4'h8, 0, 16'h0400);
        ch_prio[12+:3] = 3'h3;
        cpu_bus_req = 1'h1;
        go(24'h10);
        take(a);
        take(b);
        check({a, b}, {24'hC0, 24'hC0});
        n = 0;
        repeat (5) begin
            take(who);
            n += (who === 24'h4);
        end
        check(n > 0, 1);
        cpu_bus_req = 1'h0;
        ch_cancel[4] = 1'h1;
        tick();
        ch_cancel = '0;
        check(ch_active[4], 0);
        repeat (8) tick();
    endtask : t_cpu
    task automatic t_prio;
        wdesc(11, 16'h0, 4'h8, 0, 16'h0B00);
        wdesc(12, 16'h0, 4'h8, 0, 16'h0C00);
        wdesc(13, 16'h0, 4'h8, 0, 16'h0D00);
        ch_prio[33+:9] = {3'h1, 3'h2, 3'h5};
        go(24'h1800);
        repeat (3) begin
            take(who);
            check(who, 24'hC);
        end
        slow = 2'h3;
        n = 0;
        while (dma_grant !== 1'h1 && n < 20) begin
            tick();
            n++;
        end
        go(24'h2000);
        check({dma_grant, dma_ch}, 6'h2C);
        take(a);
        take(b);
        check({a, b}, {24'hC, 24'hD});
        slow = 2'h0;
        stop();
    endtask : t_prio
    task automatic t_rr;
        wdesc(14, 16'h0, 4'h8, 0, 16'h0E00);
        wdesc(15, 16'h0, 4'h8, 0, 16'h0F00);
        ch_prio[42+:6] = {3'h6, 3'h6};
        go(24'hC000);
        take(a);
        take(b);
        take(c);
        check({a != b, c}, {1'h1, a});
        ch_rr_off[15] = 1'h1;
        repeat (3) begin
            take(who);
            check(who, 24'hF);
        end
        ch_stall[15] = 1'h1;
        repeat (3) begin
            take(who);
            check(who, 24'hE);
        end
        ch_stall = '0;
        ch_rr_off = '0;
        stop();
    endtask : t_rr
    task automatic t_fair;
        wdesc(16, 16'h0, 4'h8, 0, 16'h1600);
        wdesc(17, 16'h0, 4'h8, 0, 16'h1700);
        wdesc(18, 16'h0, 4'h8, 0, 16'h1800);
        ch_prio[48+:9] = {3'h1, 3'h3, 3'h2};
        fair_en = 1'h1;
        go(24'h30000);
        n = 0;
        repeat (64) begin
            take(who);
            n += (who === 24'h11);
        end
        check(n, 16);
        fair_en = 1'h0;
        n = 0;
        repeat (16) begin
            take(who);
            n += (who === 24'h11);
        end
        check(n, 0);
        fair_en = 1'h1;
        go(24'h40000);
        take(who);
        repeat (12) begin
            take(who);
            check(who, 24'h12);
        end
        stop();
    endtask : t_fair

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        for (int i = 0; i < 24; i++) ch_first_desc[7*i+:7] = 7'(i);
        repeat (5) @(posedge core_clk);
        #1;
        reset_n = 1'h1;
        check({cpu_grant, dma_grant, ch_active}, 26'h0);
        tick();
        t_simple();
        t_cpu();
        t_prio();
        t_rr();
        t_fair();
        report_and_stop();
    end
endmodule : dpa_arbiter_bench
`default_nettype wire
